// ==== verilog/dcsw_params.svh ====
// Command codes, field positions, reset values and selector values for
// the drive command/status word map.
// Assumes it is included by the modules that decode codes.
`ifndef DCSW_PARAMS_SVH
`define DCSW_PARAMS_SVH

// Read command codes.
`define DCSW_RD_OPER 16'h0100
`define DCSW_RD_FREQ 16'h0101
`define DCSW_RD_RSVA_LO 16'h0102
`define DCSW_RD_RSVA_HI 16'h0106
`define DCSW_RD_OVR 16'h0107
`define DCSW_RD_UNUSB_LO 16'h0108
`define DCSW_RD_UNUSB_HI 16'h010f
`define DCSW_RD_STATUS 16'h0110

// Write command codes.
`define DCSW_WR_OPER 16'h0200
`define DCSW_WR_FREQ 16'h0201
`define DCSW_WR_RSVA_LO 16'h0202
`define DCSW_WR_RSVA_HI 16'h0206
`define DCSW_WR_OVR 16'h0207
`define DCSW_WR_UNUSB_LO 16'h0208
`define DCSW_WR_UNUSB_HI 16'h020f

// Operation command word fields.
`define DCSW_OP_FWD 0
`define DCSW_OP_REV 1
`define DCSW_OP_MFI_LO 2
`define DCSW_OP_MFI_HI 6
`define DCSW_OP_EXT_FAULT 8
`define DCSW_OP_FAULT_RESET 9
`define DCSW_OP_HIST_CLEAR 14
`define DCSW_OP_COAST 15
`define DCSW_OPER_WMASK 16'hc37f

// Output override fields.
`define DCSW_OVR_OUT1 0
`define DCSW_OVR_OC1 1
`define DCSW_OVR_OC2 2
`define DCSW_OVR_WMASK 16'h0007

// Drive status word fields.
`define DCSW_ST_RUN 0
`define DCSW_ST_ZERO 1
`define DCSW_ST_REV 2
`define DCSW_ST_RESET_IN 3
`define DCSW_ST_SPEED_AGREE 4
`define DCSW_ST_READY 5
`define DCSW_ST_MINOR 6
`define DCSW_ST_MAJOR 7
`define DCSW_ST_OPLINK 8
`define DCSW_ST_PWR_RECOV 9
`define DCSW_ST_REMOTE 10
`define DCSW_ST_RELAY 11
`define DCSW_ST_OC1 12
`define DCSW_ST_OC2 13

// Selector values and reset values.
`define DCSW_BUS_CTRL_SEL 8'h12
`define DCSW_OPLINK_DETECT_OFF 8'h00
`define DCSW_WORD_RESET 16'h0000

`endif

// ==== verilog/dcsw_pkg.sv ====
// Types shared by the command/status word block and its helpers.
// Assumes nothing beyond the parameter header.
`default_nettype none
package dcsw_pkg;
  // State of the rising-edge pulse helper.
  typedef struct packed {
    logic prev;
    logic pulse;
  } dcsw_edge_t;

  // Whole state of the command/status word block.
  typedef struct packed {
    logic [15:0] oper;
    logic [15:0] freq;
    logic [15:0] ovr;
    logic [15:0] status;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic rsp_error;
    logic fwd;
    logic rev;
    logic [4:0] mfi;
    logic ext_fault;
    logic coast;
    logic out1;
    logic oc1;
    logic oc2;
  } dcsw_state_t;
endpackage
`default_nettype wire

// ==== verilog/dcsw_edge_pulse.sv ====
// One-cycle pulse on each rising edge of a level.
// Assumes the level is synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module dcsw_edge_pulse
  import dcsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic pulse
);
  dcsw_edge_t st;
  dcsw_edge_t next_st;

  // A held level gives only one pulse, so a command bit left set acts once.
  always_comb begin
    next_st = st;
    next_st.prev = level;
    next_st.pulse = level & ~st.prev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;
endmodule // dcsw_edge_pulse
`default_nettype wire

// ==== verilog/dcsw_override_sel.sv ====
// Chooses between the bus override bit and the drive's own output value.
// Assumes the selector is a static configuration value.
`timescale 1ns/100ps
`default_nettype none
`include "dcsw_params.svh"
module dcsw_override_sel
  import dcsw_pkg::*;
#(
  parameter logic [7:0] BUS_SEL = `DCSW_BUS_CTRL_SEL
) (
  input wire logic [7:0] func_sel,
  input wire logic bus_bit,
  input wire logic local_value,
  output logic value
);
  // Bus takes the output only when its function is set to bus control.
  assign value = (func_sel == BUS_SEL) ? bus_bit : local_value;
endmodule // dcsw_override_sel
`default_nettype wire

// ==== verilog/dcsw_top.sv ====
// Command/status word map of a drive's fieldbus interface.
// Assumes one command per cycle at most, synchronous to SYS_CLK.
//
// Overview of operation
// R1: Bit 0 forward run, bit 1 reverse.
// R2: Bit 8 raises bus external fault, stops.
// R3: Bit F turns output off, coasting.
// R4: Override bit 0 drives output 1 when 18.
// R5: Override bits 1,2 drive open collectors when 18.
// R6: Status bit 0 shows running.
// R7: Status bit 1 shows zero speed.
// R8: Status bit 2 shows reverse running.
// R9: Status bit 3 shows reset input present.
// R10: Status bit 5 shows ready for operation.
// R11: Status bit 6 shows minor fault.
// R12: Status bit 7 shows major fault.
// R13: Status bit 8 operator link fault, gated.
// R14: Status bit B shows fault relay.
// R15: Status bits C, D show open collectors.
// R16: Command bits 2-6 are inputs 3-7.
// R17: Bit 9 resets fault, E clears history.
// R18: Reserved bits read zero, no effect.
`timescale 1ns/100ps
`default_nettype none
`include "dcsw_params.svh"
module dcsw_top
  import dcsw_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [15:0] CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  output logic RSP_VALID,
  output logic [15:0] RSP_RDATA,
  output logic RSP_ERROR,
  input wire logic DRV_RUNNING,
  input wire logic DRV_REVERSE,
  input wire logic DRV_ZERO_SPEED,
  input wire logic DRV_RESET_INPUT,
  input wire logic DRV_SPEED_AGREE,
  input wire logic DRV_READY,
  input wire logic DRV_MINOR_FAULT,
  input wire logic DRV_MAJOR_FAULT,
  input wire logic DRV_POWER_RECOVERED,
  input wire logic DRV_BUS_RUN_RIGHT,
  input wire logic OPERATOR_LINK_FAULT,
  input wire logic [7:0] OPERATOR_FAULT_ACTION_SELECT,
  input wire logic FAULT_RELAY_CONTACT_A,
  input wire logic [7:0] OUTPUT1_FUNCTION_SELECT,
  input wire logic [7:0] OC_OUTPUT1_FUNCTION_SELECT,
  input wire logic [7:0] OC_OUTPUT2_FUNCTION_SELECT,
  input wire logic OUTPUT1_LOCAL,
  input wire logic OC_OUTPUT1_LOCAL,
  input wire logic OC_OUTPUT2_LOCAL,
  output logic FWD_RUN_CMD,
  output logic REV_RUN_CMD,
  output logic [4:0] MF_INPUT,
  output logic BUS_EXTERNAL_FAULT,
  output logic COAST_STOP,
  output logic FAULT_RESET_PULSE,
  output logic HISTORY_CLEAR_PULSE,
  output logic [15:0] FREQ_SETPOINT,
  output logic MF_OUTPUT1,
  output logic OPEN_COLLECTOR_OUTPUT_1,
  output logic OPEN_COLLECTOR_OUTPUT_2,
  output logic REMOTE_INPUT_TWO,
  output logic REMOTE_INPUT_SIX,
  output logic REMOTE_INPUT_SEVEN
);

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers.

  dcsw_state_t st;
  dcsw_state_t next_st;
  logic sel_out1;
  logic sel_oc1;
  logic sel_oc2;
  logic rd_hit;
  logic rd_zero;
  logic wr_hit;
  logic wr_ignore;
  logic [15:0] status_now;
  logic stop_req;

  // Overridable outputs, one selector per output.
  dcsw_override_sel u_sel_out1 (
    .func_sel(OUTPUT1_FUNCTION_SELECT),
    .bus_bit(st.ovr[`DCSW_OVR_OUT1]),
    .local_value(OUTPUT1_LOCAL),
    .value(sel_out1)
  );

  dcsw_override_sel u_sel_oc1 (
    .func_sel(OC_OUTPUT1_FUNCTION_SELECT),
    .bus_bit(st.ovr[`DCSW_OVR_OC1]),
    .local_value(OC_OUTPUT1_LOCAL),
    .value(sel_oc1)
  );

  dcsw_override_sel u_sel_oc2 (
    .func_sel(OC_OUTPUT2_FUNCTION_SELECT),
    .bus_bit(st.ovr[`DCSW_OVR_OC2]),
    .local_value(OC_OUTPUT2_LOCAL),
    .value(sel_oc2)
  );

  // Fault clearing acts once per setting of the bit, not while it is held.
  dcsw_edge_pulse u_fault_reset (
    .clk(SYS_CLK),
    .rst(RST),
    .level(st.oper[`DCSW_OP_FAULT_RESET]), // R17
    .pulse(FAULT_RESET_PULSE)
  );

  dcsw_edge_pulse u_hist_clear (
    .clk(SYS_CLK),
    .rst(RST),
    .level(st.oper[`DCSW_OP_HIST_CLEAR]), // R17
    .pulse(HISTORY_CLEAR_PULSE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly from the drive's present conditions.

  always_comb begin
    status_now = `DCSW_WORD_RESET;
    status_now[`DCSW_ST_RUN] = DRV_RUNNING; // R6
    status_now[`DCSW_ST_ZERO] = DRV_ZERO_SPEED; // R7
    status_now[`DCSW_ST_REV] = DRV_RUNNING & DRV_REVERSE; // R8
    status_now[`DCSW_ST_RESET_IN] = DRV_RESET_INPUT; // R9
    status_now[`DCSW_ST_SPEED_AGREE] = DRV_SPEED_AGREE;
    status_now[`DCSW_ST_READY] = DRV_READY; // R10
    status_now[`DCSW_ST_MINOR] = DRV_MINOR_FAULT; // R11
    status_now[`DCSW_ST_MAJOR] = DRV_MAJOR_FAULT; // R12
    // A link fault is only reported when detection is switched on.
    status_now[`DCSW_ST_OPLINK] = OPERATOR_LINK_FAULT &
      (OPERATOR_FAULT_ACTION_SELECT != `DCSW_OPLINK_DETECT_OFF); // R13
    status_now[`DCSW_ST_PWR_RECOV] = DRV_POWER_RECOVERED;
    status_now[`DCSW_ST_REMOTE] = DRV_BUS_RUN_RIGHT;
    status_now[`DCSW_ST_RELAY] = FAULT_RELAY_CONTACT_A; // R14
    // The pin state is the registered output, so bus reads match the pins.
    status_now[`DCSW_ST_OC1] = st.oc1; // R15
    status_now[`DCSW_ST_OC2] = st.oc2; // R15
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.

  always_comb begin
    rd_hit = 1'b0;
    rd_zero = 1'b0;
    wr_hit = 1'b0;
    wr_ignore = 1'b0;
    if (!CMD_WRITE) begin
      rd_hit = (CMD_CODE == `DCSW_RD_OPER) || (CMD_CODE == `DCSW_RD_FREQ) ||
               (CMD_CODE == `DCSW_RD_OVR) || (CMD_CODE == `DCSW_RD_STATUS);
      rd_zero = ((CMD_CODE >= `DCSW_RD_RSVA_LO) &&
                 (CMD_CODE <= `DCSW_RD_RSVA_HI)) ||
                ((CMD_CODE >= `DCSW_RD_UNUSB_LO) &&
                 (CMD_CODE <= `DCSW_RD_UNUSB_HI)); // R18
    end else begin
      wr_hit = (CMD_CODE == `DCSW_WR_OPER) || (CMD_CODE == `DCSW_WR_FREQ) ||
               (CMD_CODE == `DCSW_WR_OVR);
      wr_ignore = ((CMD_CODE >= `DCSW_WR_RSVA_LO) &&
                   (CMD_CODE <= `DCSW_WR_RSVA_HI)) ||
                  ((CMD_CODE >= `DCSW_WR_UNUSB_LO) &&
                   (CMD_CODE <= `DCSW_WR_UNUSB_HI)); // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_st = st;
    next_st.rsp_valid = CMD_VALID;
    next_st.rsp_data = `DCSW_WORD_RESET;
    next_st.rsp_error = 1'b0;
    next_st.status = status_now;
    if (CMD_VALID) begin
      next_st.rsp_error = ~(rd_hit | rd_zero | wr_hit | wr_ignore);
      if (rd_hit) begin
        case (CMD_CODE)
          `DCSW_RD_OPER: next_st.rsp_data = st.oper;
          `DCSW_RD_FREQ: next_st.rsp_data = st.freq;
          `DCSW_RD_OVR: next_st.rsp_data = st.ovr;
          `DCSW_RD_STATUS: next_st.rsp_data = st.status;
          default: next_st.rsp_data = `DCSW_WORD_RESET;
        endcase
      end
      if (wr_hit) begin
        case (CMD_CODE)
          `DCSW_WR_OPER: begin
            next_st.oper = CMD_WDATA & `DCSW_OPER_WMASK; // R18
          end
          `DCSW_WR_FREQ: begin
            next_st.freq = CMD_WDATA;
          end
          `DCSW_WR_OVR: begin
            next_st.ovr = CMD_WDATA & `DCSW_OVR_WMASK; // R18
          end
          default: begin
            next_st.freq = st.freq;
          end
        endcase
      end
    end
    // Run commands follow the word, but a fault or coast request stops them.
    next_st.fwd = st.oper[`DCSW_OP_FWD] & ~st.oper[`DCSW_OP_REV] &
                  ~stop_req; // R1 R2 R3
    next_st.rev = st.oper[`DCSW_OP_REV] & ~st.oper[`DCSW_OP_FWD] &
                  ~stop_req; // R1 R2 R3
    next_st.mfi = st.oper[`DCSW_OP_MFI_HI:`DCSW_OP_MFI_LO]; // R16
    next_st.ext_fault = st.oper[`DCSW_OP_EXT_FAULT]; // R2
    next_st.coast = st.oper[`DCSW_OP_COAST]; // R3
    next_st.out1 = sel_out1; // R4
    next_st.oc1 = sel_oc1; // R5
    next_st.oc2 = sel_oc2; // R5
  end

  // An external fault or coast request both remove the run command.
  assign stop_req = st.oper[`DCSW_OP_EXT_FAULT] | st.oper[`DCSW_OP_COAST];

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.

  assign RSP_VALID = st.rsp_valid;
  assign RSP_RDATA = st.rsp_data;
  assign RSP_ERROR = st.rsp_error;
  assign FWD_RUN_CMD = st.fwd;
  assign REV_RUN_CMD = st.rev;
  assign MF_INPUT = st.mfi;
  assign BUS_EXTERNAL_FAULT = st.ext_fault;
  assign COAST_STOP = st.coast;
  assign FREQ_SETPOINT = st.freq;
  assign MF_OUTPUT1 = st.out1;
  assign REMOTE_INPUT_TWO = st.out1; // R4
  assign OPEN_COLLECTOR_OUTPUT_1 = st.oc1;
  assign REMOTE_INPUT_SIX = st.oc1; // R5
  assign OPEN_COLLECTOR_OUTPUT_2 = st.oc2;
  assign REMOTE_INPUT_SEVEN = st.oc2; // R5

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_fwd_run_cmd: assert property ( // R1
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_VALID && CMD_WRITE && CMD_CODE == `DCSW_WR_OPER &&
     CMD_WDATA[15:0] == 16'h0001)
    |=> ##1 FWD_RUN_CMD && !REV_RUN_CMD)
    else $error("forward word did not give forward run");

  a_rev_run_cmd: assert property ( // R1
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_VALID && CMD_WRITE && CMD_CODE == `DCSW_WR_OPER &&
     CMD_WDATA[15:0] == 16'h0002)
    |=> ##1 REV_RUN_CMD && !FWD_RUN_CMD)
    else $error("reverse word did not give reverse run");

  a_ext_fault_stop: assert property ( // R2
    @(posedge SYS_CLK) disable iff (RST)
    BUS_EXTERNAL_FAULT |-> !FWD_RUN_CMD && !REV_RUN_CMD)
    else $error("run command present during bus external fault");

  a_coast_stop: assert property ( // R3
    @(posedge SYS_CLK) disable iff (RST)
    COAST_STOP |-> !FWD_RUN_CMD && !REV_RUN_CMD)
    else $error("run command present during coast stop");

  a_out1_override: assert property ( // R4
    @(posedge SYS_CLK) disable iff (RST)
    (OUTPUT1_FUNCTION_SELECT == `DCSW_BUS_CTRL_SEL)
    |=> MF_OUTPUT1 == $past(st.ovr[`DCSW_OVR_OUT1]) &&
        REMOTE_INPUT_TWO == MF_OUTPUT1)
    else $error("output 1 does not follow its override bit");

  a_oc_local: assert property ( // R5
    @(posedge SYS_CLK) disable iff (RST)
    (OC_OUTPUT1_FUNCTION_SELECT != `DCSW_BUS_CTRL_SEL)
    |=> OPEN_COLLECTOR_OUTPUT_1 == $past(OC_OUTPUT1_LOCAL))
    else $error("open collector 1 overridden without bus selection");

  a_status_read: assert property ( // R6
    @(posedge SYS_CLK) disable iff (RST)
    (DRV_RUNNING ##1 (CMD_VALID && !CMD_WRITE &&
      CMD_CODE == `DCSW_RD_STATUS))
    |=> RSP_VALID && RSP_RDATA[`DCSW_ST_RUN])
    else $error("status read missed the running bit");

  a_rev_status: assert property ( // R8
    @(posedge SYS_CLK) disable iff (RST)
    (DRV_RUNNING && DRV_REVERSE) |=> st.status[`DCSW_ST_REV])
    else $error("reverse run not shown in status");

  a_oplink_gated: assert property ( // R13
    @(posedge SYS_CLK) disable iff (RST)
    (OPERATOR_FAULT_ACTION_SELECT == `DCSW_OPLINK_DETECT_OFF)
    |=> !st.status[`DCSW_ST_OPLINK])
    else $error("operator link fault shown while detection is off");

  a_oc_status: assert property ( // R15
    @(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> st.status[`DCSW_ST_OC1] == $past(OPEN_COLLECTOR_OUTPUT_1) &&
             st.status[`DCSW_ST_OC2] == $past(OPEN_COLLECTOR_OUTPUT_2))
    else $error("status does not mirror open collector outputs");

  a_reset_pulse: assert property ( // R17
    @(posedge SYS_CLK) disable iff (RST)
    FAULT_RESET_PULSE |=> !FAULT_RESET_PULSE)
    else $error("fault reset pulse longer than one cycle");

  a_reserved_zero: assert property ( // R18
    @(posedge SYS_CLK) disable iff (RST)
    (st.oper & ~`DCSW_OPER_WMASK) == 16'h0000 &&
    (st.ovr & ~`DCSW_OVR_WMASK) == 16'h0000)
    else $error("reserved command bits are not zero");

  a_oc2_local: assert property ( // R5
    @(posedge SYS_CLK) disable iff (RST)
    (OC_OUTPUT2_FUNCTION_SELECT != `DCSW_BUS_CTRL_SEL)
    |=> OPEN_COLLECTOR_OUTPUT_2 == $past(OC_OUTPUT2_LOCAL) &&
        REMOTE_INPUT_SEVEN == OPEN_COLLECTOR_OUTPUT_2)
    else $error("open collector 2 overridden without bus selection");

  a_hist_pulse: assert property ( // R17
    @(posedge SYS_CLK) disable iff (RST)
    HISTORY_CLEAR_PULSE |=> !HISTORY_CLEAR_PULSE)
    else $error("history clear pulse longer than one cycle");

  a_ready_status: assert property ( // R10
    @(posedge SYS_CLK) disable iff (RST)
    DRV_READY |=> st.status[`DCSW_ST_READY])
    else $error("ready condition not shown in status");

endmodule // dcsw_top
`default_nettype wire

// ==== sim/dcsw_bus_master.sv ====
// Fieldbus master model that issues command codes one at a time.
// Assumes the answer strobe follows the taking edge by one clock.
`timescale 1ns/100ps
`default_nettype none
module dcsw_bus_master (
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_error,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [15:0] cmd_code,
  output logic [15:0] cmd_wdata,
  output logic timed_out
);
  // Idle values at time zero; a missing answer is remembered for the end.
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 16'h0000;
    cmd_wdata = 16'h0000;
    timed_out = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Command is held until the answer strobe is seen or four clocks pass, then released.
  // Released fields carry the inverse, so a stale value can never match.
  task automatic xfer(input logic wr, input logic [15:0] code,
    input logic [15:0] wdata, output logic [15:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wdata;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 4);
    if (rsp_valid !== 1'b1) begin
      timed_out = 1'b1;
    end
    rdata = rsp_rdata;
    err = rsp_error;
    cmd_valid = 1'b0;
    cmd_write = ~wr;
    cmd_code = ~code;
    cmd_wdata = ~wdata;
  endtask
endmodule // dcsw_bus_master
`default_nettype wire

// ==== sim/test_drive_command_status_words.sv ====
// Self-checking bench for the drive command/status word map.
// Assumes the design files and the bus master model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_drive_command_status_words;
  logic sys_clk;
  logic rst = 1'b1;
  logic cmd_valid, cmd_write, rsp_valid, rsp_error, timed_out;
  logic [15:0] cmd_code, cmd_wdata, rsp_rdata, freq;
  logic [11:0] drv = 12'h000;
  logic [7:0] fsel = 8'h00;
  logic [7:0] osel = 8'h01;
  logic [2:0] loc = 3'b000;
  logic fwd, rev, extf, coast, frp, hcp, out1, oc1, oc2, ri2, ri6, ri7;
  logic [4:0] mfi;
  int errors, checked, nf, nh;
  int pos [12] = '{0, 2, 1, 3, 4, 5, 6, 7, 9, 10, 8, 11};
  logic [15:0] odat [8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0101,
    16'h8001, 16'h007c, 16'h0028, 16'hffff};
  logic [8:0] oexp [8] = '{9'h100, 9'h080, 9'h000, 9'h040, 9'h020,
    9'h01f, 9'h00a, 9'h07f};
  wire logic [5:0] pins = {out1, ri2, oc1, ri6, oc2, ri7};
  wire logic [8:0] ctl = {fwd, rev, extf, coast, mfi};

  // Clock of 5 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  dcsw_bus_master i_dcsw_bus_master (.clk(sys_clk), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .timed_out(timed_out));

  dcsw_top i_dcsw_top (.SYS_CLK(sys_clk), .RST(rst), .CMD_VALID(cmd_valid),
    .CMD_WRITE(cmd_write), .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_ERROR(rsp_error),
    .DRV_RUNNING(drv[0]), .DRV_REVERSE(drv[1]), .DRV_ZERO_SPEED(drv[2]),
    .DRV_RESET_INPUT(drv[3]), .DRV_SPEED_AGREE(drv[4]),
    .DRV_READY(drv[5]), .DRV_MINOR_FAULT(drv[6]),
    .DRV_MAJOR_FAULT(drv[7]), .DRV_POWER_RECOVERED(drv[8]),
    .DRV_BUS_RUN_RIGHT(drv[9]), .OPERATOR_LINK_FAULT(drv[10]),
    .OPERATOR_FAULT_ACTION_SELECT(osel), .FAULT_RELAY_CONTACT_A(drv[11]),
    .OUTPUT1_FUNCTION_SELECT(fsel), .OC_OUTPUT1_FUNCTION_SELECT(fsel),
    .OC_OUTPUT2_FUNCTION_SELECT(fsel), .OUTPUT1_LOCAL(loc[0]),
    .OC_OUTPUT1_LOCAL(loc[1]), .OC_OUTPUT2_LOCAL(loc[2]),
    .FWD_RUN_CMD(fwd), .REV_RUN_CMD(rev), .MF_INPUT(mfi),
    .BUS_EXTERNAL_FAULT(extf), .COAST_STOP(coast),
    .FAULT_RESET_PULSE(frp), .HISTORY_CLEAR_PULSE(hcp),
    .FREQ_SETPOINT(freq), .MF_OUTPUT1(out1),
    .OPEN_COLLECTOR_OUTPUT_1(oc1), .OPEN_COLLECTOR_OUTPUT_2(oc2),
    .REMOTE_INPUT_TWO(ri2), .REMOTE_INPUT_SIX(ri6),
    .REMOTE_INPUT_SEVEN(ri7));

  // Pulse counters; a level stuck high would be counted every cycle.
  always @(posedge sys_clk) begin
    if (frp === 1'b1) nf++;
    if (hcp === 1'b1) nh++;
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared comparison and access tasks.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic rd(input logic [15:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic e;
    i_dcsw_bus_master.xfer(1'b0, code, 16'h0000, d, e);
    check(d, exp);
    check({15'h0, e}, 16'h0000);
  endtask

  task automatic wr(input logic [15:0] code, input logic [15:0] data);
    logic [15:0] d;
    logic e;
    i_dcsw_bus_master.xfer(1'b1, code, data, d, e);
    check({15'h0, e}, 16'h0000);
  endtask

  // A refused command answers with the error flag and no data.
  task automatic bad(input logic w, input logic [15:0] code);
    logic [15:0] d;
    logic e;
    i_dcsw_bus_master.xfer(w, code, 16'hffff, d, e);
    check(d, 16'h0000);
    check({15'h0, e}, 16'h0001);
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic drive(input logic [11:0] v);
    @(posedge sys_clk);
    #1;
    drv = v;
    settle();
  endtask

  task automatic tally_and_finish();
    // A command that never got its answer counts as a mismatch.
    if (timed_out === 1'b1)
      errors++;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog sized well above the fewer than two hundred cycles the tests need.
  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rd(16'h0100, 16'h0000);
    rd(16'h0107, 16'h0000);
    rd(16'h0110, 16'h0000);
    check({7'h0, ctl}, 16'h0000);
    // Run, fault, coast and input bits, with masked readback.
    for (int i = 0; i < 8; i++) begin
      wr(16'h0200, odat[i]);
      rd(16'h0100, odat[i] & 16'hc37f);
      settle();
      check({7'h0, ctl}, {7'h0, oexp[i]});
    end
    // Each drive condition lights its own status bit; reverse needs run.
    wr(16'h0200, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      drive((12'h001 << i) | {11'h0, i == 1});
      rd(16'h0110, (16'h0001 << pos[i]) | {15'h0, i == 1});
    end
    osel = 8'h00;
    drive(12'h400);
    rd(16'h0110, 16'h0000);
    drive(12'h000);
    // Override bits under bus control, then the local values.
    fsel = 8'h12;
    wr(16'h0207, 16'hffff);
    rd(16'h0107, 16'h0007);
    settle();
    check({10'h0, pins}, 16'h003f);
    rd(16'h0110, 16'h3000);
    wr(16'h0207, 16'h0002);
    settle();
    check({10'h0, pins}, 16'h000c);
    fsel = 8'h00;
    loc = 3'b101;
    settle();
    check({10'h0, pins}, 16'h0033);
    rd(16'h0110, 16'h2000);
    // Clear actions fire once per rising bit, not while it stays set.
    settle();
    nf = 0;
    nh = 0;
    wr(16'h0200, 16'h0200);
    wr(16'h0200, 16'h0200);
    settle();
    check(nf[15:0], 16'h0001);
    check(nh[15:0], 16'h0000);
    wr(16'h0200, 16'h4000);
    settle();
    check(nh[15:0], 16'h0001);
    check(nf[15:0], 16'h0001);
    wr(16'h0201, 16'h1234);
    rd(16'h0101, 16'h1234);
    settle();
    check(freq, 16'h1234);
    // Reserved places read zero and ignore writes; unknown codes refused.
    rd(16'h0102, 16'h0000);
    rd(16'h0106, 16'h0000);
    rd(16'h0108, 16'h0000);
    rd(16'h010f, 16'h0000);
    wr(16'h0202, 16'hffff);
    wr(16'h020f, 16'hffff);
    bad(1'b0, 16'h0300);
    bad(1'b1, 16'h0110);
    rd(16'h0100, 16'h4000);
    tally_and_finish();
  end
endmodule // test_drive_command_status_words
`default_nettype wire
